//--- hw/ctc_defs.svh
`ifndef CTC_DEFS_SVH
`define CTC_DEFS_SVH

// Register byte offsets
`define CTC_OFS_TX_PENDING   8'h00
`define CTC_OFS_TX_CANCEL    8'h04
`define CTC_OFS_TX_DONE      8'h08
`define CTC_OFS_ABORT_DONE   8'h0c

// Field layout: mailboxes 1..7 sit in bits 9..15, 8..15 in bits 0..7
`define CTC_RSVD_BIT         8
`define CTC_MBX_MASK         16'hfeff
`define CTC_HI_MBX_BASE      4'h8
`define CTC_RST_VAL          16'h0000

// Bus constants
`define CTC_HTRANS_NONSEQ    2'h2
`define CTC_HRESP_OKAY       1'h0

`endif

//--- hw/ctc_pkg.sv
package ctc_pkg;

	// Data-phase tracking of the bus slave
	typedef enum logic [1:0] {
		CTC_PH_IDLE  = 2'b00,
		CTC_PH_WRITE = 2'b01,
		CTC_PH_READ  = 2'b10
	} ctc_phase_t;

	typedef logic [15:0] ctc_mbx_vec_t;

endpackage : ctc_pkg

//--- hw/ctc_ahb_slv.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctc_defs.svh"

module ctc_ahb_slv
	import ctc_pkg::*;
(
	input  wire logic        ref_clk,     // Module clock
	input  wire logic        reset_n,     // Async reset, active low
	input  wire logic        hsel,        // Slave select
	input  wire logic [31:0] haddr,       // Byte address
	input  wire logic [1:0]  htrans,      // Transfer type
	input  wire logic        hwrite,      // Write when high
	input  wire logic [2:0]  hsize,       // Transfer size
	input  wire logic [31:0] hwdata,      // Write data
	input  wire logic        hready,      // Bus ready
	output logic             hreadyout,   // Slave ready
	output logic             hresp,       // Response
	output logic [31:0]      hrdata,      // Read data
	output logic             reg_wr,      // One-cycle write strobe
	output logic [7:0]       reg_addr,    // Latched byte offset
	output logic [15:0]      reg_wdata,   // Write data, low half
	input  wire logic [15:0] reg_rdata    // Read value for reg_addr
);

	ctc_phase_t phase_r, phase_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic       take;

	// Address phase taken on any selected NONSEQ transfer
	assign take = hsel && hready && (htrans == `CTC_HTRANS_NONSEQ);

	always_comb begin
		phase_nxt = phase_r;
		addr_nxt  = addr_r;
		if (hready) begin
			phase_nxt = CTC_PH_IDLE;
			if (take) begin
				phase_nxt = hwrite ? CTC_PH_WRITE : CTC_PH_READ;
				addr_nxt  = haddr[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= CTC_PH_IDLE;
			addr_r  <= 8'h00;
		end else begin
			phase_r <= phase_nxt;
			addr_r  <= addr_nxt;
		end
	end

	// Zero wait states: every data phase completes in its first cycle
	assign hreadyout = 1'b1;
	assign hresp     = `CTC_HRESP_OKAY;
	assign reg_addr  = addr_r;
	assign reg_wdata = hwdata[15:0];
	// Narrow sizes are accepted as whole words; the master only issues words
	assign reg_wr    = (phase_r == CTC_PH_WRITE);
	assign hrdata    = (phase_r == CTC_PH_READ) ? {16'h0000, reg_rdata} : 32'h0000_0000;

	logic unused_size;
	assign unused_size = ^hsize;

endmodule : ctc_ahb_slv
`default_nettype wire

//--- hw/ctc_tx_ctrl.sv
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "ctc_defs.svh"

module ctc_tx_ctrl
	import ctc_pkg::*;
#(
	parameter int MBX_BITS = 4            // Width of a mailbox number
) (
	input  wire logic                ref_clk,        // 20 MHz module clock
	input  wire logic                reset_n,        // Async reset, active low
	input  wire logic                hsel,           // AHB select
	input  wire logic [31:0]         haddr,          // AHB address
	input  wire logic [1:0]          htrans,         // AHB transfer type
	input  wire logic                hwrite,         // AHB write
	input  wire logic [2:0]          hsize,          // AHB size
	input  wire logic [31:0]         hwdata,         // AHB write data
	input  wire logic                hready,         // AHB ready in
	output logic                     hreadyout,      // AHB ready out
	output logic                     hresp,          // AHB response
	output logic [31:0]              hrdata,         // AHB read data
	output logic [15:0]              tx_pending_bits,// Messages in arbitration wait
	input  wire logic                eng_frame_busy, // Engine has a frame on the bus
	input  wire logic [MBX_BITS-1:0] eng_frame_mbx,  // Mailbox of that frame
	input  wire logic                eng_tx_done     // Pulse: that frame sent error-free
);

	// Register layout position of mailbox n; 0 and out-of-range give none
	function automatic ctc_mbx_vec_t mbx_onehot(input logic [MBX_BITS-1:0] n);
		ctc_mbx_vec_t v;
		v = 16'h0000;
		if (n != '0 && n < `CTC_HI_MBX_BASE)
			v[n[2:0] + 4'h8] = 1'b1;
		else if (n >= `CTC_HI_MBX_BASE && n <= 4'hf)
			v[n[2:0]] = 1'b1;
		return v;
	endfunction : mbx_onehot

	// Only the fifteen mailbox bits are ever stored
	function automatic ctc_mbx_vec_t mbx_only(input ctc_mbx_vec_t v);
		return v & `CTC_MBX_MASK;
	endfunction : mbx_only

	logic         reg_wr;
	logic [7:0]   reg_addr;
	logic [15:0]  reg_wdata;
	logic [15:0]  reg_rdata;

	ctc_ahb_slv u_slv (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.reg_wr    (reg_wr),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_rdata (reg_rdata)
	);

	ctc_mbx_vec_t pend_r, pend_nxt;
	ctc_mbx_vec_t canc_r, canc_nxt;
	ctc_mbx_vec_t done_r, done_nxt;
	ctc_mbx_vec_t abrt_r, abrt_nxt;

	ctc_mbx_vec_t pend_set;     // Software sets pending bits
	ctc_mbx_vec_t canc_set;     // Software requests cancellation
	ctc_mbx_vec_t done_clr;     // Write-1-to-clear on done flags
	ctc_mbx_vec_t abrt_clr;     // Write-1-to-clear on abort flags
	ctc_mbx_vec_t lock;         // Mailbox whose frame is on the bus
	ctc_mbx_vec_t done_ev;      // Transmission completed this cycle
	ctc_mbx_vec_t abort_ev;     // Cancellation completed this cycle
	ctc_mbx_vec_t drop_ev;      // Cancel request with nothing to cancel

	// Write decode; bit 8 is masked so reserved bits never store
	always_comb begin
		pend_set = 16'h0000;
		canc_set = 16'h0000;
		done_clr = 16'h0000;
		abrt_clr = 16'h0000;
		if (reg_wr) begin
			unique case (reg_addr)
				`CTC_OFS_TX_PENDING: pend_set = mbx_only(reg_wdata);
				`CTC_OFS_TX_CANCEL:  canc_set = mbx_only(reg_wdata);
				`CTC_OFS_TX_DONE:    done_clr = mbx_only(reg_wdata);
				`CTC_OFS_ABORT_DONE: abrt_clr = mbx_only(reg_wdata);
				default: ;
			endcase
		end
	end

	// Engine events mapped into register layout
	always_comb begin
		lock     = eng_frame_busy ? mbx_onehot(eng_frame_mbx) : 16'h0000;
		done_ev  = eng_tx_done ? (mbx_onehot(eng_frame_mbx) & pend_r) : 16'h0000;
		// A frame on the bus is shielded from cancel and must run to its end
		abort_ev = canc_r & pend_r & ~lock & ~done_ev;
		drop_ev  = canc_r & ~pend_r;
	end

	// Next values; a software set wins over a same-cycle hardware clear
	always_comb begin
		pend_nxt = (pend_r & ~done_ev & ~abort_ev) | pend_set;
		canc_nxt = (canc_r & ~abort_ev & ~done_ev & ~drop_ev) | canc_set;
		// Hardware only ever sets these; an event beats a same-cycle clear
		done_nxt = (done_r & ~done_clr) | done_ev;
		abrt_nxt = (abrt_r & ~abrt_clr) | abort_ev;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_r <= `CTC_RST_VAL;
			canc_r <= `CTC_RST_VAL;
			done_r <= `CTC_RST_VAL;
			abrt_r <= `CTC_RST_VAL;
		end else begin
			pend_r <= pend_nxt;
			canc_r <= canc_nxt;
			done_r <= done_nxt;
			abrt_r <= abrt_nxt;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		unique case (reg_addr)
			`CTC_OFS_TX_PENDING: reg_rdata = pend_r;
			`CTC_OFS_TX_CANCEL:  reg_rdata = canc_r;
			`CTC_OFS_TX_DONE:    reg_rdata = done_r;
			`CTC_OFS_ABORT_DONE: reg_rdata = abrt_r;
			default:             reg_rdata = 16'h0000;
		endcase
	end

	assign tx_pending_bits = pend_r;

	// Checks guarding the control logic
	sequence s_cancel_armed;
		(abort_ev != 16'h0000);
	endsequence

	sequence s_abort_seen;
		((abrt_r & $past(abort_ev)) == $past(abort_ev))
			&& ((pend_r & $past(abort_ev) & ~$past(pend_set)) == 16'h0000);
	endsequence

	property p_cancel_aborts;
		@(posedge ref_clk) disable iff (!reset_n)
		s_cancel_armed |=> s_abort_seen;
	endproperty
	a_cancel_aborts: assert property (p_cancel_aborts)
		else $error("cancel did not abort waiting message");

	property p_cancel_clears;
		@(posedge ref_clk) disable iff (!reset_n)
		(abort_ev != 16'h0000)
			|=> ((canc_r & $past(abort_ev) & ~$past(canc_set)) == 16'h0000);
	endproperty
	a_cancel_clears: assert property (p_cancel_clears)
		else $error("cancel bit stayed after cancellation");

	property p_rsvd_zero;
		@(posedge ref_clk) disable iff (!reset_n)
		!canc_r[`CTC_RSVD_BIT] && !done_r[`CTC_RSVD_BIT] && !abrt_r[`CTC_RSVD_BIT];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bit 8 became set");

	property p_done_sets;
		@(posedge ref_clk) disable iff (!reset_n)
		(done_ev != 16'h0000) |=> ((done_r & $past(done_ev)) == $past(done_ev));
	endproperty
	a_done_sets: assert property (p_done_sets)
		else $error("done flag not set after transmission");

	property p_abort_only_on_cancel;
		@(posedge ref_clk) disable iff (!reset_n)
		##1 ((abrt_r & ~$past(abrt_r) & ~$past(canc_r)) == 16'h0000);
	endproperty
	a_abort_only_on_cancel: assert property (p_abort_only_on_cancel)
		else $error("abort flag set without a cancel request");

	property p_flags_sticky;
		@(posedge ref_clk) disable iff (!reset_n)
		##1 (($past(done_r) & ~done_r & ~$past(done_clr)) == 16'h0000)
			&& (($past(abrt_r) & ~abrt_r & ~$past(abrt_clr)) == 16'h0000);
	endproperty
	a_flags_sticky: assert property (p_flags_sticky)
		else $error("flag cleared without a write of 1");

	property p_map_mbx1;
		@(posedge ref_clk) disable iff (!reset_n)
		(eng_tx_done && eng_frame_mbx == 4'h1 && pend_r[9]) |=> done_r[9];
	endproperty
	a_map_mbx1: assert property (p_map_mbx1)
		else $error("mailbox 1 not mapped to bit 9");

	property p_map_mbx8;
		@(posedge ref_clk) disable iff (!reset_n)
		(eng_tx_done && eng_frame_mbx == 4'h8 && pend_r[0]) |=> done_r[0];
	endproperty
	a_map_mbx8: assert property (p_map_mbx8)
		else $error("mailbox 8 not mapped to bit 0");

	property p_pend_sets;
		@(posedge ref_clk) disable iff (!reset_n)
		(pend_set != 16'h0000) |=> ((tx_pending_bits & $past(pend_set)) == $past(pend_set));
	endproperty
	a_pend_sets: assert property (p_pend_sets)
		else $error("pending bit not set by write");

	property p_pend_clears;
		@(posedge ref_clk) disable iff (!reset_n)
		(done_ev != 16'h0000)
			|=> ((pend_r & $past(done_ev) & ~$past(pend_set)) == 16'h0000);
	endproperty
	a_pend_clears: assert property (p_pend_clears)
		else $error("pending bit stayed after transmission");

	property p_busy_not_aborted;
		@(posedge ref_clk) disable iff (!reset_n)
		((canc_r & pend_r & lock) != 16'h0000)
			|=> ((abrt_r & ~$past(abrt_r) & $past(lock)) == 16'h0000)
				&& ((pend_r & $past(lock & pend_r & ~done_ev)) == $past(lock & pend_r & ~done_ev));
	endproperty
	a_busy_not_aborted: assert property (p_busy_not_aborted)
		else $error("frame on bus was cancelled");

	// A cancel with nothing pending must vanish without raising an abort flag
	property p_drop_silent;
		@(posedge ref_clk) disable iff (!reset_n)
		(drop_ev != 16'h0000)
			|=> ((canc_r & $past(drop_ev) & ~$past(canc_set)) == 16'h0000)
				&& ((abrt_r & ~$past(abrt_r) & $past(drop_ev)) == 16'h0000);
	endproperty
	a_drop_silent: assert property (p_drop_silent)
		else $error("cancel without pending message left state behind");

	property p_canc_only_by_write;
		@(posedge ref_clk) disable iff (!reset_n)
		##1 ((canc_r & ~$past(canc_r) & ~$past(canc_set)) == 16'h0000);
	endproperty
	a_canc_only_by_write: assert property (p_canc_only_by_write)
		else $error("cancel bit set without a write of 1");

	property p_pend_only_by_write;
		@(posedge ref_clk) disable iff (!reset_n)
		##1 ((pend_r & ~$past(pend_r) & ~$past(pend_set)) == 16'h0000);
	endproperty
	a_pend_only_by_write: assert property (p_pend_only_by_write)
		else $error("pending bit set without a write of 1");

	property p_done_from_engine;
		@(posedge ref_clk) disable iff (!reset_n)
		##1 (((done_r & ~$past(done_r)) == 16'h0000) || $past(eng_tx_done));
	endproperty
	a_done_from_engine: assert property (p_done_from_engine)
		else $error("done flag set without a finished frame");

	// A frame for a mailbox with no pending message is not acknowledged
	property p_done_needs_pending;
		@(posedge ref_clk) disable iff (!reset_n)
		##1 ((done_r & ~$past(done_r) & ~$past(pend_r)) == 16'h0000);
	endproperty
	a_done_needs_pending: assert property (p_done_needs_pending)
		else $error("done flag set for a mailbox that was not pending");

	property p_abort_clears_pending;
		@(posedge ref_clk) disable iff (!reset_n)
		(abort_ev != 16'h0000)
			|=> ((pend_r & $past(abort_ev) & ~$past(pend_set)) == 16'h0000);
	endproperty
	a_abort_clears_pending: assert property (p_abort_clears_pending)
		else $error("pending bit stayed after cancellation");

	// The cancel of a frame that ran to its end is spent with it
	property p_busy_done_clears;
		@(posedge ref_clk) disable iff (!reset_n)
		((done_ev & canc_r) != 16'h0000)
			|=> ((canc_r & $past(done_ev) & ~$past(canc_set)) == 16'h0000);
	endproperty
	a_busy_done_clears: assert property (p_busy_done_clears)
		else $error("cancel bit stayed after its frame completed");

	property p_pend_rsvd;
		@(posedge ref_clk) disable iff (!reset_n)
		!pend_r[`CTC_RSVD_BIT];
	endproperty
	a_pend_rsvd: assert property (p_pend_rsvd)
		else $error("pending bit 8 became set");

	// Whatever offset is selected, bit 8 of the read value stays zero
	property p_read_rsvd;
		@(posedge ref_clk) disable iff (!reset_n)
		!reg_rdata[`CTC_RSVD_BIT];
	endproperty
	a_read_rsvd: assert property (p_read_rsvd)
		else $error("reserved bit 8 read as one");

endmodule : ctc_tx_ctrl
`default_nettype wire

//--- test/ctc_eng_model.sv
`timescale 1ns/1ns
`default_nettype none

module ctc_eng_model
	import ctc_pkg::*;
(
	input  wire logic       ref_clk,   // Module clock
	input  wire logic       reset_n,   // Async reset, active low
	input  wire logic       go,        // Start a frame
	input  wire logic       ok,        // Frame ends error-free
	input  wire logic [3:0] mbx,       // Mailbox of the frame
	input  wire logic [7:0] len,       // Frame length in cycles
	output logic            busy,      // Frame on the bus
	output logic [3:0]      frame_mbx, // Mailbox, 0 between frames
	output logic            done       // Error-free end pulse
);
	logic [7:0] cnt_r, cnt_nxt;
	logic [3:0] mbx_r, mbx_nxt;
	logic       ok_r, ok_nxt;

	// Load on go, then count the frame down
	always_comb begin
		cnt_nxt = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
		mbx_nxt = mbx_r;
		ok_nxt = ok_r;
		if (go) begin
			cnt_nxt = len;
			mbx_nxt = mbx;
			ok_nxt = ok;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 8'h00;
			mbx_r <= 4'h0;
			ok_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			mbx_r <= mbx_nxt;
			ok_r <= ok_nxt;
		end
	end

	// Busy spans the whole frame, so a cancel cannot slip in mid-frame
	assign busy = (cnt_r != 8'h00);
	assign frame_mbx = busy ? mbx_r : 4'h0;
	// Lost arbitration is a frame that ends with no done pulse
	assign done = busy && (cnt_r == 8'h01) && ok_r;

endmodule : ctc_eng_model

`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctc_defs.svh"

module tb import ctc_pkg::*;;
	localparam logic [7:0] P = `CTC_OFS_TX_PENDING;
	localparam logic [7:0] C = `CTC_OFS_TX_CANCEL;
	localparam logic [7:0] D = `CTC_OFS_TX_DONE;
	localparam logic [7:0] A = `CTC_OFS_ABORT_DONE;
	logic [7:0]   offs [5] = '{P, C, D, A, 8'h10}; // Every offset, the last one unmapped
	logic         ref_clk = 1'b0;
	logic         reset_n, hwrite, hreadyout, hresp, go, ok, busy, done;
	logic [31:0]  haddr, hwdata, hrdata;
	logic [1:0]   htrans;
	logic [3:0]   mbx, fmbx;
	logic [7:0]   len;
	ctc_mbx_vec_t tx_pending_bits;
	int           n_mismatch = 0;
	int           n_compared = 0;

	// 20 MHz module clock
	always #25 ref_clk = ~ref_clk;

	ctc_tx_ctrl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.tx_pending_bits(tx_pending_bits), .eng_frame_busy(busy),
		.eng_frame_mbx(fmbx), .eng_tx_done(done));

	ctc_eng_model eng_u (.ref_clk(ref_clk), .reset_n(reset_n), .go(go), .ok(ok),
		.mbx(mbx), .len(len), .busy(busy), .frame_mbx(fmbx), .done(done));

	function automatic ctc_mbx_vec_t mb(input int n);
		return 16'h0001 << (n < 8 ? n + 8 : n - 8);
	endfunction : mb

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Address phase, then data phase; both wait for hready at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		htrans <= `CTC_HTRANS_NONSEQ;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk("hresp", {31'h0, `CTC_HRESP_OKAY}, {31'h0, hresp});
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, {16'hffff, d}, q);
	endtask : wr

	// Pending is also checked at the port, in the same sampling step
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk($sformatf("reg %h", a), {16'h0000, e}, q);
		if (a == P) chk("pending port", {16'h0000, e}, {16'h0000, tx_pending_bits});
	endtask : rd

	task automatic frame(input int n, input int l, input logic k);
		go <= 1'b1;
		mbx <= n[3:0];
		len <= l[7:0];
		ok <= k;
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
	endtask : frame

	task automatic fwait();
		for (int i = 0; i < 300 && busy; i++) @(posedge ref_clk);
	endtask : fwait

	task automatic results();
		$display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results

	// Whole run needs about 420 cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_mismatch++;
		results();
	end

	initial begin
		reset_n = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		go = 1'b0;
		ok = 1'b0;
		mbx = 4'h0;
		len = 8'h00;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		foreach (offs[i]) rd(offs[i], 16'h0000);
		wr(P, 16'hffff);
		rd(P, 16'hfeff);
		wr(C, 16'hffff);
		rd(C, 16'h0000);
		rd(P, 16'h0000);
		rd(A, 16'hfeff);
		wr(A, 16'h0000);
		rd(A, 16'hfeff);
		wr(A, mb(3) | mb(12) | 16'h0100);
		rd(A, 16'hfeff & ~(mb(3) | mb(12)));
		wr(A, 16'hffff);
		rd(A, 16'h0000);
		// Each mailbox in turn: its bit position, send, done flag, clear
		for (int n = 1; n < 16; n++) begin
			wr(P, mb(n));
			rd(P, mb(n));
			frame(n, 4, 1'b1);
			fwait();
			rd(P, 16'h0000);
			wr(D, ~mb(n));
			rd(D, mb(n));
			wr(D, mb(n));
			rd(D, 16'h0000);
		end
		// Cancel lands while the frame is already on the bus
		wr(P, mb(5));
		frame(5, 20, 1'b1);
		wr(C, mb(5));
		rd(C, mb(5));
		fwait();
		rd(D, mb(5));
		rd(A, 16'h0000);
		rd(C, 16'h0000);
		// Frame loses arbitration, so the held cancel then aborts
		wr(P, mb(9));
		frame(9, 20, 1'b0);
		wr(C, mb(9));
		fwait();
		rd(A, mb(9));
		rd(P, 16'h0000);
		wr(C, mb(2));
		rd(C, 16'h0000);
		frame(4, 4, 1'b1);
		fwait();
		rd(D, mb(5));
		wr(8'h10, 16'hffff);
		rd(8'h10, 16'h0000);
		wr(D, 16'hffff);
		wr(A, 16'hffff);
		rd(D, 16'h0000);
		rd(A, 16'h0000);
		// Reset in mid-run while pending and abort bits are held
		wr(P, 16'hffff);
		wr(C, mb(1));
		rd(A, mb(1));
		reset_n <= 1'b0;
		@(posedge ref_clk);
		reset_n <= 1'b1;
		foreach (offs[i]) rd(offs[i], 16'h0000);
		results();
	end

endmodule : tb

`default_nettype wire
